// File: bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import usb_err_pkg::*;
    // ------------------------------------------
    // Clock, bus, partner
    // ------------------------------------------
    logic        mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, go;
    logic        packet_reject, host_mode, err_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [3:0]  cmd;
    logic [12:0] ev;
    int          err_count, checks_done, rej_cnt;
    assign hready = hreadyout;  // Single slave
    // Bench clock stands in for the module clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Reject pulses seen, one per event cycle
    always @(posedge mclk) if (packet_reject === 1'b1) rej_cnt <= rej_cnt + 1;
    usb_link_model i_usb_link_model (.mclk(mclk), .go(go), .cmd(cmd), .ev(ev));
    usb_error_status_flags i_usb_error_status_flags (
        .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_packet_end(ev[0]), .bit_stuff_err(ev[1]),
        .crc16_bad(ev[2]), .crc5_bad(ev[3]), .pid_check_bad(ev[4]), .partial_byte(ev[5]),
        .addr_invalid(ev[6]), .dma_late(ev[7]), .rx_truncated(ev[8]), .sof_count_zero(ev[9]),
        .link_busy(ev[10]), .eop_seen(ev[11]), .expect_resp(ev[12]),
        .packet_reject(packet_reject), .host_mode(host_mode), .err_irq(err_irq));
    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask : chk
    // Samples hready at the rising edge, where the slave answers
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            stop_test;
        end
    endtask : wait_rdy
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h000000, a};
        wait_rdy;
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        wait_rdy;
        rd = hrdata;
        chk({31'h0, hresp}, 32'h00000000);  // Response always OKAY
    endtask : ahb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] want);  // Compare inside
        logic [31:0] r;
        ahb(1'b0, a, 32'h00000000, r);
        chk(r, want);
    endtask : rd
    task go_cmd(input logic [3:0] c);
        go <= 1'b1; cmd <= c;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
    endtask : go_cmd
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task t_regs;  // Reset values, mask layout, unmapped place
        rd(ERR_FLAGS_OFS, 32'h00000000);
        rd(ERR_MASK_OFS, 32'h00000000);
        wr(ERR_MASK_OFS, 32'hFFFFFFFF);
        rd(ERR_MASK_OFS, 32'h000000FF);
        wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h0C, 32'h00000000);
    endtask : t_regs
    task fire(input logic [3:0] c, input logic host, input logic [31:0] want);
        int r0;
        r0 = rej_cnt;
        go_cmd(c);
        chk({31'h0, host_mode}, {31'h0, host});
        rd(ERR_FLAGS_OFS, want);
        chk({31'h0, err_irq}, {31'h0, want != 0});
        chk(rej_cnt - r0, (c == 4'h1 || c == 4'h2) ? 1 : 0);
        wr(ERR_FLAGS_OFS, want);
        rd(ERR_FLAGS_OFS, 32'h00000000);
    endtask : fire
    task t_events;  // Every source but the turnaround time-out; the bit 1 sources in both modes
        logic [31:0] tbl [1:8];
        tbl = '{32'h80, 32'h04, 32'h02, 32'h01, 32'h08, 32'h40, 32'h20, 32'h20};
        for (int c = 1; c <= 8; c++) fire(c[3:0], 1'b0, tbl[c]);
        fire(4'hC, 1'b0, 32'h00000000);
        fire(4'h9, 1'b0, 32'h00000000);
        wr(CTRL_OFS, 32'h00000001);
        @(posedge mclk);
        chk({31'h0, host_mode}, 32'h00000001);
        fire(4'h9, 1'b1, 32'h00000002);
        fire(4'h3, 1'b1, 32'h00000000);
        wr(CTRL_OFS, 32'h00000000);
    endtask : t_events
    task t_pri;  // Zero keeps, set beats clear
        logic [31:0] r;
        go_cmd(4'h4);
        wr(ERR_FLAGS_OFS, 32'h00000000);
        rd(ERR_FLAGS_OFS, 32'h00000001);
        go <= 1'b1; cmd <= 4'h4;
        ahb(1'b1, ERR_FLAGS_OFS, 32'h00000001, r);
        go <= 1'b0;
        rd(ERR_FLAGS_OFS, 32'h00000001);
        wr(ERR_FLAGS_OFS, 32'h00000001);
        wr(ERR_MASK_OFS, 32'h00000000);
        go_cmd(4'h4);
        @(posedge mclk);
        chk({31'h0, err_irq}, 32'h00000000);
        wr(ERR_MASK_OFS, 32'h00000001);
        @(posedge mclk);
        chk({31'h0, err_irq}, 32'h00000001);
    endtask : t_pri
    task t_turn;  // Idle after packet end, then a cancelled wait
        wr(ERR_FLAGS_OFS, 32'h000000FF);
        go_cmd(4'hA);
        repeat (60) @(posedge mclk);
        rd(ERR_FLAGS_OFS, 32'h00000000);
        repeat (5) @(posedge mclk);
        rd(ERR_FLAGS_OFS, 32'h00000010);
        wr(ERR_FLAGS_OFS, 32'h00000010);
        go_cmd(4'hA);
        repeat (20) @(posedge mclk);
        go_cmd(4'h9);
        repeat (70) @(posedge mclk);
        rd(ERR_FLAGS_OFS, 32'h00000000);
    endtask : t_turn
    task t_rst2;  // Reset in mid-run clears a set flag
        go_cmd(4'h1);
        rd(ERR_FLAGS_OFS, 32'h00000080);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(ERR_FLAGS_OFS, 32'h00000000);
    endtask : t_rst2
    initial begin
        sys_rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; haddr = 32'h0; hwdata = 32'h0;
        go = 1'b0; cmd = 4'h0; err_count = 0; checks_done = 0; rej_cnt = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_events;
        t_pri;
        t_turn;
        t_rst2;
        stop_test;
    end
endmodule : testbench

// File: bench/usb_link_model.sv
module usb_link_model (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic [3:0]  cmd,
    output logic      [12:0] ev
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------
    // Serial engine stand-in, one pulse per go
    // ------------------------------------------
    logic        go_q = 1'b0;
    logic [12:0] code_ev;
    // Command code to event lines
    always_comb begin
        case (cmd)
            4'h5:    code_ev = 13'h0021;  // Packet end, partial byte
            4'h9:    code_ev = 13'h0600;  // Frame count zero, link busy
            4'hA:    code_ev = 13'h1800;  // End of packet, reply awaited
            4'hC:    code_ev = 13'h0001;  // Packet end, whole bytes
            default: code_ev = 13'h0001 << cmd;
        endcase
    end
    // Edge of go only, so a held go never repeats an event
    initial ev = 13'h0000;
    always @(posedge mclk) begin
        go_q <= go;
        ev   <= (go && !go_q) ? code_ev : 13'h0000;
    end
endmodule : usb_link_model

// File: hdl/err_event_if.sv
interface err_event_if;
    logic [7:0] set;     // One pulse per event, flag layout
    logic       timeout; // Turnaround time-out detected
    modport source (output timeout, input set);
    modport sink   (input timeout, output set);
endinterface : err_event_if

// File: hdl/turnaround_timer.sv
module turnaround_timer
    import usb_err_pkg::*;
#(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic eop_seen,
    input  wire logic bus_active,
    input  wire logic expect_resp,
    err_event_if.source evt
);
    // Counter is sixteen bits wide, so the limit must fit in it
    if (BIT_CYCLES < 1 || BIT_CYCLES > 4095) begin : g_bad_cycles
        $error("BIT_CYCLES out of range");
    end

    localparam int LIMIT = TURNAROUND_BIT_TIMES * BIT_CYCLES;

    logic [15:0] idle_q;
    logic        arm_q;
    logic        fire;

    // ------------------------------------------------------------
    // Idle counter since the last end of packet
    // ------------------------------------------------------------
    // Fires once when idle exceeds sixteen bit times without reply
    assign fire        = arm_q && !bus_active && (idle_q == 16'(LIMIT));
    assign evt.timeout = fire;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_q <= 16'h0000;
            arm_q  <= 1'b0;
        end else if (eop_seen) begin
            idle_q <= 16'h0000;
            arm_q  <= expect_resp;
        end else if (bus_active || fire) begin
            idle_q <= 16'h0000;
            arm_q  <= 1'b0;  // A reply or the fire ends the wait
        end else if (arm_q) begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    bto_arm_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (eop_seen && expect_resp) |=> arm_q && (idle_q == 16'h0000))
        else $error("turnaround wait not armed");
    bto_cancel_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (bus_active && !eop_seen) |=> !arm_q)
        else $error("reply did not end the wait");

endmodule : turnaround_timer

// File: hdl/usb_err_pkg.sv
package usb_err_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ERR_FLAGS_OFS  = 8'h00;  // Error flag word, write one to clear
    localparam logic [7:0] ERR_MASK_OFS   = 8'h04;  // Interrupt mask, same layout
    localparam logic [7:0] CTRL_OFS       = 8'h08;  // Mode control
    localparam logic [7:0] ERR_FLAGS_RST  = 8'h00;
    localparam logic [7:0] ERR_MASK_RST   = 8'h00;

    // ------------------------------------------------------------
    // Flag positions
    // ------------------------------------------------------------
    localparam int PID_BIT   = 0;
    localparam int CRC5_BIT  = 1;  // End-of-frame flag in host mode
    localparam int CRC16_BIT = 2;
    localparam int DFN_BIT   = 3;
    localparam int BTO_BIT   = 4;
    localparam int DMA_BIT   = 5;
    localparam int BMX_BIT   = 6;
    localparam int BTS_BIT   = 7;
    localparam int HOST_BIT  = 0;  // Position in control register

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TURNAROUND_BIT_TIMES = 16;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

endpackage : usb_err_pkg

// File: hdl/usb_error_status_flags.sv
// Behaviour
// - Bit stuff violation rejects the packet and sets flag bit 7.
// - Invalid descriptor table or buffer address sets flag bit 6.
// - Late system bus grant causing overflow or underflow sets bit 5.
// - Received data packet truncated by a small buffer also sets bit 5.
// - Over 16 bit times idle after end of packet without reply sets bit 4.
// - Data field not a whole number of bytes sets bit 3.
// - CRC16 failure rejects the data packet and sets bit 2.
// - Host mode: busy when frame countdown reaches zero sets bit 1.
// - Flags set only by hardware; write one clears, zero keeps.
// - Bits 31 to 8 read zero; all flags cleared at reset.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
module usb_error_status_flags
    import usb_err_pkg::*;
#(
    parameter int BIT_CYCLES = 4  // Module clock cycles per full-speed bit
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Error events from the serial engine and DMA, one-cycle pulses
    input  wire logic        rx_packet_end,
    input  wire logic        bit_stuff_err,
    input  wire logic        crc16_bad,
    input  wire logic        crc5_bad,
    input  wire logic        pid_check_bad,
    input  wire logic        partial_byte,
    input  wire logic        addr_invalid,
    input  wire logic        dma_late,
    input  wire logic        rx_truncated,
    input  wire logic        sof_count_zero,
    input  wire logic        link_busy,
    input  wire logic        eop_seen,
    input  wire logic        expect_resp,
    // Outputs
    output logic             packet_reject,
    output logic             host_mode,
    output logic             err_irq
);
    import usb_err_pkg::*;

    // ------------------------------------------------------------
    // Parameter guard
    // ------------------------------------------------------------
    // The idle counter is sixteen bits; longer bit times would wrap it
    if (BIT_CYCLES < 1 || BIT_CYCLES > 4095) begin : g_bad_cycles
        $error("BIT_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    err_event_if evt ();

    turnaround_timer #(
        .BIT_CYCLES  (BIT_CYCLES)
    ) u_timer (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .eop_seen    (eop_seen),
        .bus_active  (link_busy),
        .expect_resp (expect_resp),
        .evt         (evt)
    );

    logic       host_q;
    logic [7:0] flags_q;
    logic [7:0] mask_q;
    logic       reject_q;
    logic [7:0] set_vec;

    // Per-flag hardware set terms
    assign set_vec[BTS_BIT]   = bit_stuff_err;
    assign set_vec[BMX_BIT]   = addr_invalid;
    assign set_vec[DMA_BIT]   = dma_late || rx_truncated;
    assign set_vec[BTO_BIT]   = evt.timeout;
    assign set_vec[DFN_BIT]   = rx_packet_end && partial_byte;
    assign set_vec[CRC16_BIT] = crc16_bad;
    // Bit 1 meaning follows the mode; the mode bit picks the source
    assign set_vec[CRC5_BIT]  = host_q ? (sof_count_zero && link_busy)
                                       : crc5_bad;
    assign set_vec[PID_BIT]   = pid_check_bad;
    assign evt.set            = set_vec;

    // ------------------------------------------------------------
    // AHB-Lite slave: one address phase, zero-wait data phase
    // ------------------------------------------------------------
    bus_state_t  st_q;
    logic [7:0]  addr_q;
    logic        wr_q;
    logic        take;
    logic        wr_flags;
    logic        wr_mask;
    logic        wr_ctrl;
    logic [7:0]  clr_vec;
    logic [31:0] rd_mux;

    // Only a selected, ready, non-idle transfer is captured
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign wr_flags  = (st_q == BUS_DATA) && wr_q && (addr_q == ERR_FLAGS_OFS);
    assign wr_mask   = (st_q == BUS_DATA) && wr_q && (addr_q == ERR_MASK_OFS);
    assign wr_ctrl   = (st_q == BUS_DATA) && wr_q && (addr_q == CTRL_OFS);
    assign clr_vec   = wr_flags ? hwdata[7:0] : 8'h00;

    // Register readback; unmapped offsets and bits 31 to 8 read zero
    function automatic logic [31:0] reg_word(
        input logic [7:0] ofs,
        input logic [7:0] flags,
        input logic [7:0] mask,
        input logic       host
    );
        case (ofs)
            ERR_FLAGS_OFS: reg_word = {24'h000000, flags};
            ERR_MASK_OFS:  reg_word = {24'h000000, mask};
            CTRL_OFS:      reg_word = {31'h00000000, host};
            default:       reg_word = 32'h00000000;
        endcase
    endfunction : reg_word

    // Decoded in the address phase, registered for the data phase
    assign rd_mux = reg_word(haddr[7:0], flags_q, mask_q, host_q);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q   <= BUS_IDLE;
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end else begin
            st_q   <= take ? BUS_DATA : BUS_IDLE;
            addr_q <= take ? haddr[7:0] : addr_q;
            wr_q   <= take && hwrite;
        end
    end

    // Read data registered for the data phase following the address
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else begin
            case (st_q)
                BUS_IDLE: hrdata <= 32'h00000000;
                BUS_DATA: hrdata <= hrdata;
                default:  hrdata <= 32'h00000000;
            endcase
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Flag, mask and control registers
    // ------------------------------------------------------------
    // Set is ORed after the clear so a coincident error survives
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= ERR_FLAGS_RST;
        end else begin
            flags_q <= (flags_q & ~clr_vec) | evt.set;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= ERR_MASK_RST;
            host_q <= 1'b0;
        end else begin
            mask_q <= wr_mask ? hwdata[7:0] : mask_q;
            host_q <= wr_ctrl ? hwdata[HOST_BIT] : host_q;
        end
    end

    // Packets with stuffing or CRC16 faults are discarded downstream
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reject_q <= 1'b0;
        end else begin
            reject_q <= bit_stuff_err || crc16_bad;
        end
    end

    assign packet_reject = reject_q;
    assign host_mode     = host_q;
    assign err_irq       = |(flags_q & mask_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_clear_write;
        wr_flags && (hwdata[7:0] != 8'h00);
    endsequence

    bts_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        bit_stuff_err |=> flags_q[BTS_BIT] && reject_q)
        else $error("bit stuff flag or reject missing");
    bmx_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        addr_invalid |=> flags_q[BMX_BIT])
        else $error("address error flag missing");
    dma_late_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dma_late |=> flags_q[DMA_BIT])
        else $error("dma late flag missing");
    dma_trunc_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_truncated |=> flags_q[DMA_BIT])
        else $error("truncation flag missing");
    bto_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        evt.timeout |=> flags_q[BTO_BIT])
        else $error("turnaround flag missing");
    dfn_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_packet_end && partial_byte) |=> flags_q[DFN_BIT])
        else $error("data size flag missing");
    crc16_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        crc16_bad |=> flags_q[CRC16_BIT] && reject_q)
        else $error("crc16 flag or reject missing");
    eof_host_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (host_q && sof_count_zero && link_busy) |=> flags_q[CRC5_BIT])
        else $error("end of frame flag missing");
    w1c_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s_clear_write |=> ((flags_q & $past(hwdata[7:0])) == ($past(set_vec) & $past(hwdata[7:0]))))
        else $error("write one did not clear");
    flag_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!wr_flags && (set_vec == 8'h00)) |=> $stable(flags_q))
        else $error("flag changed without cause");
    upper_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == BUS_DATA) |-> (hrdata[31:8] == 24'h000000))
        else $error("upper bits not zero");
    crc5_dev_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!host_q && crc5_bad) |=> flags_q[CRC5_BIT])
        else $error("token crc flag missing");
    set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (wr_flags && hwdata[PID_BIT] && pid_check_bad) |=> flags_q[PID_BIT])
        else $error("clear beat a set");

    // A newly set unmasked flag raises the interrupt next cycle
    irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ((|(set_vec & mask_q)) && !wr_mask) |=> err_irq)
        else $error("interrupt level wrong");
    pid_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pid_check_bad |=> flags_q[PID_BIT])
        else $error("packet id flag missing");

    // Sources of the other mode, or whole-byte packets, leave their bit alone
    crc5_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!host_q && !crc5_bad && !wr_flags) |=> (flags_q[CRC5_BIT] == $past(flags_q[CRC5_BIT])))
        else $error("bit 1 set without token crc fault");
    eof_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (host_q && !(sof_count_zero && link_busy) && !wr_flags) |=> (flags_q[CRC5_BIT] == $past(flags_q[CRC5_BIT])))
        else $error("bit 1 set without end of frame");
    dfn_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!(rx_packet_end && partial_byte) && !wr_flags) |=> (flags_q[DFN_BIT] == $past(flags_q[DFN_BIT])))
        else $error("size flag set on whole bytes");
    zero_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (wr_flags && (hwdata[7:0] == 8'h00)) |=> (flags_q == ($past(flags_q) | $past(set_vec))))
        else $error("zero write changed a flag");

    // Only stuffing and CRC16 faults discard a packet
    reject_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
        packet_reject |-> $past(bit_stuff_err || crc16_bad))
        else $error("reject without cause");
    dma_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ((dma_late || rx_truncated) && !bit_stuff_err && !crc16_bad) |=> !packet_reject)
        else $error("dma error rejected a packet");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    sequence s_read_addr;
        take && !hwrite;
    endsequence

    sequence s_read_data;
        (st_q == BUS_DATA) && !wr_q;
    endsequence

    read_phase_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s_read_addr |=> s_read_data)
        else $error("read data phase missing");
    flag_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (take && !hwrite && (haddr[7:0] == ERR_FLAGS_OFS)) |=> (hrdata == {24'h000000, $past(flags_q)}))
        else $error("flag readback wrong");
    mask_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_mask |=> (mask_q == $past(hwdata[7:0])))
        else $error("mask write lost");
    host_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_ctrl |=> (host_q == $past(hwdata[HOST_BIT])))
        else $error("mode write lost");

endmodule : usb_error_status_flags
